// File: design/lbp_consts.svh
// Offsets, field positions, reset values and timing counts of the LED PWM.
// Assumes inclusion by bare name from the package and the module.
// What this block does
// - Breathing period counter sized 8, 7 or 6 bits
// - Counter wraps at 255, 127 or 63
// - Output on while counter below duty cycle
// - Control off clears prescaler, period, duty, interval and hold counters and ramp state
// - Rise duty by segment step at interval pace
// - Hold at upper limit for high hold time
// - Then fall by segment step at interval pace
// - At lower limit hold, then repeat forever
// - Symmetric: segment index is duty bits 7:5
// - Asymmetric: rising segments 0-3, falling 4-7
// - Asymmetric index: falling flag, duty bits 7:6
// - Segment n uses nibble n of step, interval
// - Blink prescaler runs on slow or main clock
// - Counter advances on prescaler zero, reload low delay
// - Low delay zero means no prescaling
// - Blink counter always eight bits
// - Blink frequency is clock over 256 times (ld+1)
// - Blink duty from lower limit, 00 off, ff on
// - Control value 3 forces output on
// - Blink uses only prescale, duty, control
// - Limit writes take effect at period end
// - Delay, step, interval copied when update enabled
`ifndef LBP_CONSTS_SVH
`define LBP_CONSTS_SVH

`define LBP_OFS_CFG       8'h00
`define LBP_OFS_LIM       8'h04
`define LBP_OFS_DLY       8'h08
`define LBP_OFS_STEP      8'h0c
`define LBP_OFS_INTV      8'h10
`define LBP_OFS_ODLY      8'h14
`define LBP_OFS_STAT      8'h18

`define LBP_CFG_CTRL_LSB  0
`define LBP_CFG_SRC_BIT   2
`define LBP_CFG_SIZE_LSB  4
`define LBP_CFG_UPD_BIT   6
`define LBP_CFG_RST_BIT   7
`define LBP_CFG_SYM_BIT   16
`define LBP_LIM_MIN_LSB   0
`define LBP_LIM_MAX_LSB   8
`define LBP_DLY_LD_LSB    0
`define LBP_DLY_HD_LSB    12

`define LBP_CTRL_OFF      2'h0
`define LBP_CTRL_BREATH   2'h1
`define LBP_CTRL_BLINK    2'h2
`define LBP_CTRL_ON       2'h3
`define LBP_SIZE_8        2'h0
`define LBP_SIZE_7        2'h1
`define LBP_SIZE_6        2'h2
`define LBP_MAX_8         8'hff
`define LBP_MAX_7         8'h7f
`define LBP_MAX_6         8'h3f

`define LBP_RST_LIM       16'h0000
`define LBP_RST_DLY       24'h000000
`define LBP_RST_WORD      32'h00000000

`define LBP_CLK_HZ        200000000
`define LBP_SLOW_HZ       32768
`define LBP_SLOW_DIV      (`LBP_CLK_HZ / `LBP_SLOW_HZ)

`endif

// File: design/lbp_pkg.sv
// Types of the LED breathing and blinking PWM.
// Assumes lbp_consts.svh on the include path.
`include "lbp_consts.svh"

package lbp_pkg;

    typedef enum logic [3:0] {
        LBP_RISE    = 4'h1,
        LBP_HOLD_HI = 4'h2,
        LBP_FALL    = 4'h4,
        LBP_HOLD_LO = 4'h8
    } lbp_ramp_type;

    typedef struct packed {
        logic [1:0]   ctrl;
        logic         clk_src;
        logic [1:0]   size;
        logic         upd;
        logic         sym;
        logic [15:0]  lim_hold;
        logic [15:0]  lim;
        logic [23:0]  dly_hold;
        logic [23:0]  dly;
        logic [31:0]  step_hold;
        logic [31:0]  step;
        logic [31:0]  intv_hold;
        logic [31:0]  intv;
        logic [12:0]  tick_cnt;
        logic [11:0]  pre_cnt;
        logic [7:0]   pcnt;
        logic [7:0]   duty;
        logic [3:0]   icnt;
        logic [11:0]  hcnt;
        lbp_ramp_type ramp;
        logic         led;
        logic [31:0]  prdata;
    } lbp_state_type;

endpackage

// File: design/lbp_pwm.sv
// LED breathing and blinking PWM with APB register slave.
// Assumes one 200 MHz clock; slow 32.768 kHz rate made by a divider.
`timescale 1ns/1ps
`default_nettype none
`include "lbp_consts.svh"

module lbp_pwm #(
    parameter logic [12:0] SLOW_TICK_DIV = 13'(`LBP_SLOW_DIV)
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    output var  logic        led_out
);

    lbp_pkg::lbp_state_type q_reg;
    lbp_pkg::lbp_state_type q_next;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] size_max(input logic [1:0] sz);
        logic [7:0] m;
        unique case (sz)
            `LBP_SIZE_7: m = `LBP_MAX_7;
            `LBP_SIZE_6: m = `LBP_MAX_6;
            default:     m = `LBP_MAX_8;
        endcase
        return m;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a == `LBP_OFS_CFG || a == `LBP_OFS_LIM || a == `LBP_OFS_DLY
            || a == `LBP_OFS_STEP || a == `LBP_OFS_INTV || a == `LBP_OFS_ODLY
            || a == `LBP_OFS_STAT;
    endfunction

    logic [31:0] cfg_word;
    logic [7:0]  lim_min;
    logic [7:0]  lim_max;
    logic [11:0] ld_val;
    logic [11:0] hd_val;
    logic        breath;
    logic        blink;
    logic        slow_tick;
    logic        src_tick;
    logic        adv;
    logic        pend;
    logic [7:0]  pmax;
    logic [2:0]  seg;
    logic [3:0]  stp;
    logic [3:0]  itv;
    logic [8:0]  sum;
    logic [8:0]  floor_lvl;
    logic        acc;
    logic [31:0] wr_cfg;
    logic        soft_clr;

    always_comb begin
        cfg_word = '0;
        cfg_word[`LBP_CFG_CTRL_LSB +: 2] = q_reg.ctrl;
        cfg_word[`LBP_CFG_SRC_BIT]       = q_reg.clk_src;
        cfg_word[`LBP_CFG_SIZE_LSB +: 2] = q_reg.size;
        cfg_word[`LBP_CFG_UPD_BIT]       = q_reg.upd;
        cfg_word[`LBP_CFG_SYM_BIT]       = q_reg.sym;
    end

    assign lim_min = q_reg.lim[`LBP_LIM_MIN_LSB +: 8];
    assign lim_max = q_reg.lim[`LBP_LIM_MAX_LSB +: 8];
    assign ld_val  = q_reg.dly[`LBP_DLY_LD_LSB +: 12];
    assign hd_val  = q_reg.dly[`LBP_DLY_HD_LSB +: 12];
    assign breath  = q_reg.ctrl == `LBP_CTRL_BREATH;
    assign blink   = q_reg.ctrl == `LBP_CTRL_BLINK;
    assign acc     = psel && penable;
    assign soft_clr = acc && pwrite && paddr == `LBP_OFS_CFG && wr_cfg[`LBP_CFG_RST_BIT];

    assign pready  = 1'b1;
    assign pslverr = acc && !mapped(paddr);
    assign prdata  = q_reg.prdata;
    assign led_out = q_reg.led;

    always_comb begin
        q_next    = q_reg;
        slow_tick = q_reg.tick_cnt == SLOW_TICK_DIV - 13'h0001;
        // Breathing always paces on the slow clock
        src_tick  = (blink && q_reg.clk_src) ? 1'b1 : slow_tick;
        pmax      = breath ? size_max(q_reg.size) : `LBP_MAX_8;
        // Prescaler: counter steps when it reads zero
        adv       = breath ? src_tick : (blink && src_tick && q_reg.pre_cnt == 12'h000);
        pend      = adv && q_reg.pcnt == pmax;
        // Config bit set selects asymmetric segments
        seg       = q_reg.sym ? {q_reg.ramp == lbp_pkg::LBP_FALL, q_reg.duty[7:6]}
                  : q_reg.duty[7:5];
        stp       = q_reg.step[{seg, 2'b00} +: 4];
        itv       = q_reg.intv[{seg, 2'b00} +: 4];
        sum       = {1'b0, q_reg.duty} + {5'h00, stp};
        floor_lvl = {1'b0, lim_min} + {5'h00, stp};
        wr_cfg    = merge(cfg_word, pwdata, pstrb);

        q_next.tick_cnt = slow_tick ? 13'h0000 : q_reg.tick_cnt + 13'h0001;

        if (blink && src_tick) begin
            q_next.pre_cnt = (q_reg.pre_cnt == 12'h000) ? ld_val
                           : q_reg.pre_cnt - 12'h001;
        end
        if (adv) begin
            q_next.pcnt = pend ? 8'h00 : q_reg.pcnt + 8'h01;
        end

        if (pend) begin
            q_next.lim = q_reg.lim_hold;
            if (q_reg.upd) begin
                q_next.dly  = q_reg.dly_hold;
                q_next.step = q_reg.step_hold;
                q_next.intv = q_reg.intv_hold;
            end
        end

        // Ramp engine ticks once per period
        if (pend && breath) begin
            unique case (q_reg.ramp)
                lbp_pkg::LBP_RISE: begin
                    if (q_reg.icnt >= itv) begin
                        q_next.icnt = 4'h0;
                        if (sum >= {1'b0, lim_max}) begin
                            q_next.duty = lim_max;
                            q_next.hcnt = hd_val;
                            q_next.ramp = lbp_pkg::LBP_HOLD_HI;
                        end else begin
                            q_next.duty = sum[7:0];
                        end
                    end else begin
                        q_next.icnt = q_reg.icnt + 4'h1;
                    end
                end
                lbp_pkg::LBP_HOLD_HI: begin
                    if (q_reg.hcnt == 12'h000) begin
                        q_next.ramp = lbp_pkg::LBP_FALL;
                    end else begin
                        q_next.hcnt = q_reg.hcnt - 12'h001;
                    end
                end
                lbp_pkg::LBP_FALL: begin
                    if (q_reg.icnt >= itv) begin
                        q_next.icnt = 4'h0;
                        if ({1'b0, q_reg.duty} <= floor_lvl) begin
                            q_next.duty = lim_min;
                            q_next.hcnt = ld_val;
                            q_next.ramp = lbp_pkg::LBP_HOLD_LO;
                        end else begin
                            q_next.duty = q_reg.duty - {4'h0, stp};
                        end
                    end else begin
                        q_next.icnt = q_reg.icnt + 4'h1;
                    end
                end
                lbp_pkg::LBP_HOLD_LO: begin
                    if (q_reg.hcnt == 12'h000) begin
                        q_next.ramp = lbp_pkg::LBP_RISE;
                    end else begin
                        q_next.hcnt = q_reg.hcnt - 12'h001;
                    end
                end
            endcase
        end

        // Off clears the counters and ramp; slow-tick divider keeps running
        if (q_reg.ctrl == `LBP_CTRL_OFF) begin
            q_next.pre_cnt = 12'h000;
            q_next.pcnt    = 8'h00;
            q_next.duty    = 8'h00;
            q_next.icnt    = 4'h0;
            q_next.hcnt    = 12'h000;
            q_next.ramp    = lbp_pkg::LBP_RISE;
        end

        // Read data staged in the setup cycle
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `LBP_OFS_CFG:  q_next.prdata = cfg_word;
                `LBP_OFS_LIM:  q_next.prdata = {16'h0000, q_reg.lim_hold};
                `LBP_OFS_DLY:  q_next.prdata = {8'h00, q_reg.dly_hold};
                `LBP_OFS_STEP: q_next.prdata = q_reg.step_hold;
                `LBP_OFS_INTV: q_next.prdata = q_reg.intv_hold;
                `LBP_OFS_STAT: q_next.prdata = {4'h0, q_reg.ramp, 8'h00,
                                                q_reg.pcnt, q_reg.duty};
                default:       q_next.prdata = 32'h00000000;
            endcase
        end

        if (acc && pwrite) begin
            unique case (paddr)
                `LBP_OFS_CFG: begin
                    q_next.ctrl    = wr_cfg[`LBP_CFG_CTRL_LSB +: 2];
                    q_next.clk_src = wr_cfg[`LBP_CFG_SRC_BIT];
                    q_next.size    = wr_cfg[`LBP_CFG_SIZE_LSB +: 2];
                    q_next.upd     = wr_cfg[`LBP_CFG_UPD_BIT];
                    q_next.sym     = wr_cfg[`LBP_CFG_SYM_BIT];
                    if (wr_cfg[`LBP_CFG_RST_BIT]) begin
                        q_next = '0;
                        q_next.ramp = lbp_pkg::LBP_RISE;
                    end
                end
                `LBP_OFS_LIM: begin
                    q_next.lim_hold = 16'(merge({16'h0000, q_reg.lim_hold}, pwdata, pstrb));
                end
                `LBP_OFS_DLY: begin
                    q_next.dly_hold = 24'(merge({8'h00, q_reg.dly_hold}, pwdata, pstrb));
                end
                `LBP_OFS_STEP: q_next.step_hold = merge(q_reg.step_hold, pwdata, pstrb);
                `LBP_OFS_INTV: q_next.intv_hold = merge(q_reg.intv_hold, pwdata, pstrb);
                default: ;
            endcase
        end

        // Output follows the updated counter and duty
        unique case (q_next.ctrl)
            `LBP_CTRL_BREATH: q_next.led = q_next.pcnt < q_next.duty;
            `LBP_CTRL_BLINK:  q_next.led = (q_next.lim[7:0] == 8'hff)
                                         || (q_next.pcnt < q_next.lim[7:0]);
            `LBP_CTRL_ON:     q_next.led = 1'b1;
            default:          q_next.led = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_reg      <= '0;
            q_reg.ramp <= lbp_pkg::LBP_RISE;
        end else begin
            q_reg <= q_next;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    size_wrap_a: assert property (breath && adv && q_reg.pcnt == size_max(q_reg.size)
        |=> q_reg.pcnt == 8'h00 || q_reg.ctrl != `LBP_CTRL_BREATH)
        else $error("period counter did not wrap at size maximum");
    led_compare_a: assert property (breath |-> led_out == (q_reg.pcnt < q_reg.duty))
        else $error("breathing output disagrees with duty compare");
    off_clear_a: assert property (q_reg.ctrl == `LBP_CTRL_OFF && $past(q_reg.ctrl) == 2'h0
        |-> q_reg.pcnt == 8'h00 && q_reg.duty == 8'h00 && !led_out)
        else $error("counters not cleared while off");
    force_on_a: assert property (q_reg.ctrl == `LBP_CTRL_ON |-> led_out)
        else $error("forced-on output is low");
    blink_off_a: assert property (blink && lim_min == 8'h00 |-> !led_out)
        else $error("blink with zero duty drove output");
    limit_update_a: assert property ($changed(q_reg.lim) |-> $past(pend) || $past(soft_clr)
        || !$past(presetn))
        else $error("limits changed away from period end");
    hold_high_a: assert property (q_reg.ramp == lbp_pkg::LBP_HOLD_HI
        ##1 q_reg.ramp == lbp_pkg::LBP_HOLD_HI |-> $stable(q_reg.duty))
        else $error("duty moved during upper hold");
    rise_only_a: assert property (q_reg.ramp == lbp_pkg::LBP_RISE && breath
        ##1 q_reg.ramp == lbp_pkg::LBP_RISE && breath |-> q_reg.duty >= $past(q_reg.duty))
        else $error("duty fell while rising");
    blink_pace_a: assert property (blink && !q_reg.clk_src && !slow_tick
        |=> $stable(q_reg.pcnt) || q_reg.ctrl != `LBP_CTRL_BLINK)
        else $error("blink counter moved without a tick");

    breath_cycle_c: cover property (q_reg.ramp == lbp_pkg::LBP_HOLD_LO
        ##1 q_reg.ramp == lbp_pkg::LBP_RISE);
    fall_entry_c: cover property (q_reg.ramp == lbp_pkg::LBP_FALL && q_reg.sym == 1'b1);
    blink_wrap_c: cover property (blink && pend);
    bad_addr_c: cover property (pslverr);

endmodule

`default_nettype wire

// File: dv/lbp_led_load.sv
// LED load model: counts the clock cycles in which the LED is lit.
// Assumes led_out is an active-high level synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none

module lbp_led_load (
    input  wire logic        pclk,
    input  wire logic        led_out,
    input  wire logic        clear,
    output var  logic [15:0] lit_cycles
);
    // Pure sink, never drives back
    always_ff @(posedge pclk) begin
        if (clear) begin
            lit_cycles <= 16'h0000;
        end else if (led_out === 1'b1) begin
            lit_cycles <= lit_cycles + 16'h0001;
        end
    end
endmodule

`default_nettype wire

// File: dv/led_breathing_blinking_pwm_tb.sv
// Self-checking bench of the LED PWM: APB master tasks and an LED load.
// Assumes lbp_pwm with zero-wait APB and a short slow-tick divider.
`timescale 1ns/1ps
`default_nettype none

module led_breathing_blinking_pwm_tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        led_out;
    logic        clear;
    logic [15:0] lit;
    logic [31:0] rd;
    logic        err;
    int          failures;
    int          checks;

    lbp_pwm #(.SLOW_TICK_DIV(13'h0004)) i_lbp_pwm (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .led_out(led_out)
    );

    lbp_led_load i_lbp_led_load (
        .pclk(pclk), .led_out(led_out), .clear(clear), .lit_cycles(lit)
    );

    always #2.5 pclk = ~pclk;

    task automatic conclude();
        if (failures == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; entered and left just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 100) begin
            n++;
            @(posedge pclk);
        end
        if (n >= 100) failures++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Lit cycles over a window of n edges
    task automatic lit_over(input int n, input logic [15:0] exp, input string nm);
        clear <= 1'b1;
        @(posedge pclk);
        clear <= 1'b0;
        repeat (n) @(posedge pclk);
        @(negedge pclk);
        check(nm, {16'h0000, lit}, {16'h0000, exp});
        @(posedge pclk);
    endtask

    task automatic poll(input logic [3:0] code);
        int n;
        n = 0;
        do begin
            apb(1'b0, 8'h18, 32'h0);
            n++;
        end while (rd[27:24] !== code && n < 3000);
        if (n >= 3000) failures++;
    endtask

    logic [11:0] ld_tab  [4] = '{12'h001, 12'h000, 12'h000, 12'h000};
    logic [7:0]  min_tab [4] = '{8'h40, 8'h80, 8'h00, 8'hff};
    logic [15:0] lit_tab [4] = '{16'h0100, 16'h0200, 16'h0000, 16'h0400};

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        pstrb = 4'hf;
        clear = 1'b0;
        failures = 0;
        checks = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int a = 0; a <= 24; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            check("reset value", rd, (a == 24) ? 32'h01000000 : 32'h00000000);
        end
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h00000001);
        // Blink on pclk, size field 7-bit must be ignored
        apb(1'b1, 8'h00, 32'h00000056);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'h04, {24'h0, min_tab[i]});
            apb(1'b1, 8'h08, {20'h0, ld_tab[i]});
            repeat (600) @(posedge pclk);
            lit_over(1024, lit_tab[i], "blink lit");
        end
        // Blink on the slow tick, four pclk per count
        apb(1'b1, 8'h00, 32'h00000052);
        apb(1'b1, 8'h04, 32'h00000080);
        repeat (1100) @(posedge pclk);
        lit_over(2048, 16'h0400, "slow blink lit");
        apb(1'b1, 8'h00, 32'h00000003);
        lit_over(256, 16'h0100, "forced on");
        apb(1'b1, 8'h00, 32'h00000080);
        apb(1'b0, 8'h18, 32'h0);
        check("status after soft reset", rd, 32'h01000000);
        lit_over(64, 16'h0000, "lit after soft reset");
        // Breathing, 6-bit, asymmetric: rise step 8, fall step 4
        apb(1'b1, 8'h04, 32'h00002000);
        apb(1'b1, 8'h08, 32'h00000000);
        apb(1'b1, 8'h0c, 32'h44448888);
        apb(1'b1, 8'h10, 32'h00000000);
        apb(1'b1, 8'h00, 32'h00010061);
        // First pass runs on cleared operating copies
        poll(4'h8);
        poll(4'h2);
        check("hold high ramp", {28'h0, rd[27:24]}, 32'h00000002);
        check("hold high duty", {24'h0, rd[7:0]}, 32'h00000020);
        check("counter in 6-bit range", {31'h0, rd[15:8] <= 8'h3f}, 32'h1);
        poll(4'h4);
        while (rd[7:0] === 8'h20 && rd[27:24] === 4'h4) begin
            apb(1'b0, 8'h18, 32'h0);
        end
        check("first fall duty", {24'h0, rd[7:0]}, 32'h0000001c);
        poll(4'h8);
        check("hold low duty", {24'h0, rd[7:0]}, 32'h00000000);
        poll(4'h1);
        check("ramp repeats", {28'h0, rd[27:24]}, 32'h00000001);
        // Symmetric: falling from 20 uses segment 1
        apb(1'b1, 8'h00, 32'h00000080);
        apb(1'b1, 8'h04, 32'h00002000);
        apb(1'b1, 8'h0c, 32'h44448888);
        apb(1'b1, 8'h00, 32'h00000061);
        poll(4'h8);
        poll(4'h4);
        while (rd[7:0] === 8'h20 && rd[27:24] === 4'h4) begin
            apb(1'b0, 8'h18, 32'h0);
        end
        check("symmetric fall duty", {24'h0, rd[7:0]}, 32'h00000018);
        conclude();
    end

    initial begin
        #400000;
        failures++;
        conclude();
    end
endmodule

`default_nettype wire
